// ==== shared/pcc_regs.svh ====
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// Capture data path
`define PCC_BUS_WIDTH        8
`define PCC_STAGE_WIDTH      32
`define PCC_STAGE_COUNT      8
`define PCC_PIN_COUNT        16
`define PCC_PIN_SEL_WIDTH    4
`define PCC_FIRST_PIN_RESET  4'h1

// Shift timer
`define PCC_TIMER_WIDTH      16
`define PCC_SHIFT_CMP_RESET  16'h003F
`define PCC_TIMER_STEP       16'h0002
`define PCC_TIMER_LAST       16'h0001

// Sensor clock timer
`define PCC_REF_CMP_RESET    16'h0201
`define PCC_REF_CMP_ALT      16'h0202
`define PCC_REF_HIGH_LSB     8
`define PCC_REF_LOW_LSB      0

// Status counters
`define PCC_COUNT_WIDTH      16

`endif

// ==== shared/pcc_pkg.sv ====
`include "pcc_regs.svh"

package pcc_pkg;

    typedef enum logic {
        PCC_IDLE,
        PCC_RUN
    } pcc_timer_state_t;

    typedef struct packed {
        logic dma_req;
        logic overrun;
        logic line_active;
    } pcc_status_t;

    typedef struct packed {
        logic [`PCC_BUS_WIDTH-1:0] data;
        logic                      line_valid;
    } pcc_pixel_t;

    typedef logic [`PCC_STAGE_COUNT*`PCC_STAGE_WIDTH-1:0] pcc_block_t;

endpackage : pcc_pkg

// ==== rtl/pcc_ref_clock.sv ====
`timescale 1ns/1ps
`include "pcc_regs.svh"

module pcc_ref_clock
    import pcc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Configuration
    input  wire logic [15:0] compare,
    // Sensor pin
    output logic             sensor_ref_clock_out
);

    logic [7:0] count;
    logic       level;

    wire  [7:0] high_load = compare[`PCC_REF_HIGH_LSB +: 8];
    wire  [7:0] low_load  = compare[`PCC_REF_LOW_LSB +: 8];
    wire        phase_end = (count == 8'h00);
    wire  [7:0] next_count = phase_end ? (level ? low_load : high_load) : count - 8'h01;
    wire        next_level = phase_end ? ~level : level;

    // Free-running dual 8-bit PWM: low for low byte + 1 cycles, high for high byte + 1
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= 8'h00;
            level <= 1'b0;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end

    // Output starts low after reset, no inversion toward the pin
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sensor_ref_clock_out <= 1'b0;
        end else begin
            sensor_ref_clock_out <= next_level;
        end
    end

endmodule : pcc_ref_clock

// ==== rtl/pcc_capture.sv ====
`timescale 1ns/1ps
`include "pcc_regs.svh"

// Summary of operation
// - Capture stages receive, sampling on the rising shift clock edge.
// - Eight consecutive input pins from a selectable first pin, 8 bits per shift.
// - Pin levels pass uninverted; high pin captures as one.
// - Stages chained downward; only the highest stage reads the data pins.
// - No start or stop bits; every shift clock carries one byte.
// - Line-valid is an active-high trigger; pixel clock is an uninverted input.
// - Timer enabled and reset on line-valid rise, disabled on its fall.
// - Timer counts on the pixel clock; shift clock equals that clock.
// - Single 16-bit counter; output starts low, unaffected by timer reset.
// - Compare value 63 gives 32 shifts per compare event.
// - Reference clock timer: dual 8-bit PWM, always on, uninverted pin.
// - Compare 0x0201 at 120 MHz gives 24 MHz, not 50 percent duty.
// - Compare 0x0202 optionally gives 20 MHz at 50 percent duty.
// - Compare event stores all stages at once and sets the request flag.
// - After compare the timer reloads and continues while line-valid is high.
module pcc_capture
    import pcc_pkg::*;
#(
    parameter int          PIN_COUNT    = `PCC_PIN_COUNT,
    parameter int          STAGES       = `PCC_STAGE_COUNT,
    parameter logic [15:0] REF_CMP_INIT = `PCC_REF_CMP_RESET
)
(
    // System clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    // Sensor link
    input  wire logic                     pixel_clk,
    input  wire logic [PIN_COUNT-1:0]     data_pins,
    input  wire logic                     line_valid,
    output logic                          sensor_ref_clock_out,
    // Configuration
    input  wire logic [3:0]               first_data_pin,
    input  wire logic [15:0]              shift_timer_compare,
    input  wire logic                     ref_clock_alt,
    // Holding buffer read side
    output logic                          dma_req,
    input  wire logic                     dma_ack,
    output pcc_block_t                    first_holding_buffer,
    // Status
    input  wire logic                     overrun_clear,
    output pcc_status_t                   status,
    output logic [`PCC_COUNT_WIDTH-1:0]   line_count,
    output logic [`PCC_COUNT_WIDTH-1:0]   store_count
);

    localparam int SW = `PCC_STAGE_WIDTH;
    localparam int BW = `PCC_BUS_WIDTH;

    // ------------------------------------------------------------------
    // Reference clock generation, system domain
    // ------------------------------------------------------------------
    wire [15:0] ref_compare = ref_clock_alt ? `PCC_REF_CMP_ALT : REF_CMP_INIT;

    // Compare values must keep the sensor inside its 10 to 48 MHz window
    pcc_ref_clock u_ref_clock (
        .sys_clk              (sys_clk),
        .sys_rst              (sys_rst),
        .compare              (ref_compare),
        .sensor_ref_clock_out (sensor_ref_clock_out)
    );

    // ------------------------------------------------------------------
    // Pixel clock domain: reset and quasi-static configuration
    // ------------------------------------------------------------------
    // The pixel clock stops between frames, so its reset only takes
    // effect while the sensor is running.
    logic [1:0]  prst_sync;
    logic [3:0]  pin_sel_s1;
    logic [3:0]  pin_sel;
    logic [15:0] cmp_s1;
    logic [15:0] cmp_p;

    wire prst = prst_sync[1];

    always_ff @(posedge pixel_clk) begin
        prst_sync <= {prst_sync[0], sys_rst};
    end

    always_ff @(posedge pixel_clk) begin
        pin_sel_s1 <= first_data_pin;
        pin_sel    <= pin_sel_s1;
        cmp_s1     <= shift_timer_compare;
        cmp_p      <= cmp_s1;
    end

    // ------------------------------------------------------------------
    // Pixel clock domain: input pipeline, sampled on the rising edge
    // ------------------------------------------------------------------
    pcc_pixel_t pix_s1;
    pcc_pixel_t pix;

    wire [PIN_COUNT-1:0] pins_shifted = data_pins >> pin_sel;
    wire [BW-1:0]        pin_byte     = pins_shifted[BW-1:0];

    // Data and line-valid travel together so they stay aligned to the byte
    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            pix_s1 <= '0;
            pix    <= '0;
        end else begin
            pix_s1 <= '{data: pin_byte, line_valid: line_valid};
            pix    <= pix_s1;
        end
    end

    // ------------------------------------------------------------------
    // Shift timer
    // ------------------------------------------------------------------
    pcc_timer_state_t timer_state;
    logic             lv_prev;
    logic [15:0]      timer_count;
    logic             timer_out;

    wire lv_rise    = pix.line_valid & ~lv_prev;
    wire lv_fall    = ~pix.line_valid & lv_prev;
    wire running    = (timer_state == PCC_RUN) & pix.line_valid;
    // Counter drops by two per pixel clock period, counted on the rising edge only
    wire cmp_event  = running & (timer_count <= `PCC_TIMER_LAST);
    wire shift_en   = running | lv_rise;
    wire [15:0] next_timer_count = cmp_event ? cmp_p : timer_count - `PCC_TIMER_STEP;

    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            lv_prev <= 1'b0;
        end else begin
            lv_prev <= pix.line_valid;
        end
    end

    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            timer_state <= PCC_IDLE;
        end else begin
            unique case (timer_state)
                PCC_IDLE: begin
                    if (lv_rise) begin
                        timer_state <= PCC_RUN;
                    end
                end
                PCC_RUN: begin
                    if (lv_fall) begin
                        timer_state <= PCC_IDLE;
                    end
                end
            endcase
        end
    end

    // The rising edge of line-valid already carries the first byte
    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            timer_count <= '0;
        end else if (lv_rise) begin
            timer_count <= cmp_p - `PCC_TIMER_STEP;
        end else if (running) begin
            timer_count <= next_timer_count;
        end
    end

    // Output low on enable; a trigger reset alone leaves it untouched
    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            timer_out <= 1'b0;
        end else if (lv_rise) begin
            timer_out <= 1'b0;
        end else if (cmp_event) begin
            timer_out <= ~timer_out;
        end
    end

    // ------------------------------------------------------------------
    // Capture stages, chained from the highest down
    // ------------------------------------------------------------------
    logic [SW-1:0] stage [STAGES];
    logic [SW-1:0] hold  [STAGES];
    logic          store_tgl;
    logic          line_end_tgl;

    // Timer gated off outside lines, so no framing bits ever enter
    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage[i] <= '0;
            end
        end else if (shift_en) begin
            for (int i = 0; i < STAGES - 1; i++) begin
                stage[i] <= {stage[i+1][BW-1:0], stage[i][SW-1:BW]};
            end
            stage[STAGES-1] <= {pix.data, stage[STAGES-1][SW-1:BW]};
        end
    end

    wire last_shift = cmp_event;

    // Holding buffers catch the stages including the byte of this shift
    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            for (int i = 0; i < STAGES; i++) begin
                hold[i] <= '0;
            end
        end else if (last_shift) begin
            for (int i = 0; i < STAGES - 1; i++) begin
                hold[i] <= {stage[i+1][BW-1:0], stage[i][SW-1:BW]};
            end
            hold[STAGES-1] <= {pix.data, stage[STAGES-1][SW-1:BW]};
        end
    end

    always_ff @(posedge pixel_clk) begin
        if (prst) begin
            store_tgl    <= 1'b0;
            line_end_tgl <= 1'b0;
        end else begin
            store_tgl    <= store_tgl ^ last_shift;
            line_end_tgl <= line_end_tgl ^ lv_fall;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the system domain
    // ------------------------------------------------------------------
    // Holding buffers stay still for 32 pixel clocks after a store, far
    // longer than the toggle takes to cross, so the word copy is safe.
    logic [2:0] store_sync;
    logic [2:0] line_sync;
    logic [1:0] active_sync;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            store_sync  <= '0;
            line_sync   <= '0;
            active_sync <= '0;
        end else begin
            store_sync  <= {store_sync[1:0], store_tgl};
            line_sync   <= {line_sync[1:0], line_end_tgl};
            active_sync <= {active_sync[0], timer_state == PCC_RUN};
        end
    end

    wire store_evt = store_sync[2] ^ store_sync[1];
    wire line_evt  = line_sync[2] ^ line_sync[1];

    pcc_block_t hold_flat;

    always_comb begin
        hold_flat = '0;
        for (int i = 0; i < STAGES; i++) begin
            hold_flat[i*SW +: SW] = hold[i];
        end
    end

    // Same word at a fixed place for every request; lowest stage in low bits
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            first_holding_buffer <= '0;
        end else if (store_evt) begin
            first_holding_buffer <= hold_flat;
        end
    end

    // ------------------------------------------------------------------
    // Request and overrun flags: a new store wins over a clear
    // ------------------------------------------------------------------
    logic overrun;

    wire next_dma_req = store_evt | (dma_req & ~dma_ack);
    wire next_overrun = (store_evt & dma_req & ~dma_ack) | (overrun & ~overrun_clear);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dma_req <= 1'b0;
            overrun <= 1'b0;
        end else begin
            dma_req <= next_dma_req;
            overrun <= next_overrun;
        end
    end

    // Frame length of 1200 requests is counted by the reader, not here
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            store_count <= '0;
            line_count  <= '0;
        end else begin
            if (store_evt) begin
                store_count <= store_count + 16'h0001;
            end
            if (line_evt) begin
                line_count <= line_count + 16'h0001;
            end
        end
    end

    assign status = '{dma_req: dma_req, overrun: overrun, line_active: active_sync[1]};

endmodule : pcc_capture

// ==== verification/pcc_capture_monitor.sv ====
`timescale 1ns/1ps
`include "pcc_regs.svh"

module pcc_capture_monitor
    import pcc_pkg::*;
(
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        sys_rst,
    // Observed ports
    input wire logic                        ref_clock_alt,
    input wire logic                        sensor_ref_clock_out,
    input wire logic                        dma_req,
    input wire logic                        dma_ack,
    input wire pcc_block_t                  first_holding_buffer,
    input wire logic                        overrun_clear,
    input wire pcc_status_t                 status,
    input wire logic [`PCC_COUNT_WIDTH-1:0] line_count,
    input wire logic [`PCC_COUNT_WIDTH-1:0] store_count
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // Remaining low cycles, then three high, then low again
    sequence ref_lo1_s;
        !sensor_ref_clock_out ##1 sensor_ref_clock_out [*3] ##1 !sensor_ref_clock_out;
    endsequence
    sequence ref_lo2_s;
        !sensor_ref_clock_out [*2] ##1 sensor_ref_clock_out [*3] ##1 !sensor_ref_clock_out;
    endsequence

    chk_ref_default: assert property ($fell(sensor_ref_clock_out) && !ref_clock_alt |=> ref_lo1_s)
        else $error("reference clock shape wrong for default compare");
    chk_ref_alt: assert property ($fell(sensor_ref_clock_out) && ref_clock_alt |=> ref_lo2_s)
        else $error("reference clock shape wrong for alternate compare");
    chk_req_hold: assert property (dma_req && !dma_ack |=> dma_req)
        else $error("request dropped without acknowledge");
    chk_req_clear: assert property (dma_req && dma_ack |=> !dma_req || store_count != $past(store_count))
        else $error("request not cleared by acknowledge");
    chk_store_req: assert property ($changed(store_count) |-> ##[0:1] dma_req)
        else $error("store did not raise request");
    chk_req_cause: assert property ($rose(dma_req) |-> ##[0:1] store_count != $past(store_count, 3))
        else $error("request raised without store");
    chk_buf_stable: assert property ($stable(store_count) [*3] |-> $stable(first_holding_buffer))
        else $error("holding buffer changed without store");
    chk_ovr_sticky: assert property (status.overrun && !overrun_clear |=> status.overrun)
        else $error("overrun flag not sticky");
    chk_ovr_clear: assert property (overrun_clear && !dma_req |=> !status.overrun)
        else $error("overrun flag not cleared");
    chk_line_step: assert property ($changed(line_count) |-> line_count == $past(line_count) + 16'h0001)
        else $error("line count did not step by one");
    chk_store_step: assert property ($changed(store_count) |-> store_count == $past(store_count) + 16'h0001)
        else $error("store count did not step by one");
endmodule : pcc_capture_monitor

bind pcc_capture pcc_capture_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .ref_clock_alt(ref_clock_alt), .sensor_ref_clock_out(sensor_ref_clock_out),
    .dma_req(dma_req), .dma_ack(dma_ack), .first_holding_buffer(first_holding_buffer),
    .overrun_clear(overrun_clear), .status(status), .line_count(line_count),
    .store_count(store_count));

// ==== verification/pcc_sensor_model.sv ====
`timescale 1ns/1ps

module pcc_sensor_model (
    // Link outputs
    output logic        pixel_clk,
    output logic [15:0] data_pins,
    output logic        line_valid,
    // Line control from the bench
    input wire logic        start,
    input wire logic [7:0]  len,
    input wire logic [7:0]  base,
    input wire logic [3:0]  pin
);
    logic seen;
    int   cnt;

    // Pixel clock runs between lines too, as blanking pixels do
    initial begin
        pixel_clk = 1'b0;
        #7;
        forever #32 pixel_clk = ~pixel_clk;
    end

    initial begin
        data_pins = 16'h0000;
        line_valid = 1'b0;
        seen = 1'b0;
        cnt = 0;
    end

    // Unused pins and idle lines toggle so stale values never look valid
    always @(negedge pixel_clk) begin
        if (start !== seen) begin
            seen = start;
            cnt = 0;
        end
        data_pins = ~data_pins;
        line_valid = (cnt < int'(len));
        if (line_valid) begin
            data_pins[pin +: 8] = base ^ 8'(cnt * 37);
            cnt++;
        end
    end
endmodule : pcc_sensor_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "pcc_regs.svh"

module testbench
    import pcc_pkg::*;
;
    logic sys_clk, sys_rst, pixel_clk, line_valid, sensor_ref_clock_out;
    logic ref_clock_alt, dma_req, dma_ack, overrun_clear, start;
    logic [15:0] data_pins, shift_timer_compare, line_count, store_count;
    logic [7:0] len, base;
    logic [3:0] first_data_pin;
    pcc_block_t first_holding_buffer;
    pcc_status_t status;
    int mismatches, total_checks, seed;

    pcc_capture dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .pixel_clk(pixel_clk),
        .data_pins(data_pins), .line_valid(line_valid),
        .sensor_ref_clock_out(sensor_ref_clock_out), .first_data_pin(first_data_pin),
        .shift_timer_compare(shift_timer_compare), .ref_clock_alt(ref_clock_alt),
        .dma_req(dma_req), .dma_ack(dma_ack), .first_holding_buffer(first_holding_buffer),
        .overrun_clear(overrun_clear), .status(status), .line_count(line_count),
        .store_count(store_count));
    pcc_sensor_model u_sensor (.pixel_clk(pixel_clk), .data_pins(data_pins),
        .line_valid(line_valid), .start(start), .len(len), .base(base), .pin(first_data_pin));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic pcc_block_t exp_block(input logic [7:0] b, input int k0);
        for (int k = 0; k < 32; k++) begin
            exp_block[8*k +: 8] = b ^ 8'((k0 + k) * 37);
        end
    endfunction : exp_block

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic do_reset;
        sys_rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask : do_reset

    task automatic run_line(input int n);
        logic [15:0] lc;
        lc = line_count;
        len = 8'(n);
        base = 8'($urandom);
        start = ~start;
        repeat (20) @(negedge sys_clk);
        check(256'(status.line_active), 256'(1));
        for (int i = 0; i < 800 && line_count === lc; i++) @(negedge sys_clk);
        check(256'(line_count === lc), 256'(0));
        check(256'(status.line_active), 256'(0));
    endtask : run_line

    task automatic wait_store(input logic [15:0] t);
        for (int i = 0; i < 100 && store_count !== t; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        check(256'(store_count), 256'(t));
        check(256'(dma_req), 256'(1));
    endtask : wait_store

    task automatic ack;
        dma_ack = 1'b1;
        @(negedge sys_clk);
        dma_ack = 1'b0;
        @(negedge sys_clk);
        check(256'(dma_req), 256'(0));
    endtask : ack

    task automatic ref_shape(input int hi, input int lo);
        int h, l;
        for (int i = 0; i < 20 && sensor_ref_clock_out !== 1'b0; i++) @(negedge sys_clk);
        for (int i = 0; i < 20 && sensor_ref_clock_out !== 1'b1; i++) @(negedge sys_clk);
        for (h = 0; h < 20 && sensor_ref_clock_out === 1'b1; h++) @(negedge sys_clk);
        for (l = 0; l < 20 && sensor_ref_clock_out === 1'b0; l++) @(negedge sys_clk);
        check(256'(h), 256'(hi));
        check(256'(l), 256'(lo));
    endtask : ref_shape

    initial begin
        #400000;
        mismatches++;
        test_done;
    end

    initial begin
        {sys_rst, dma_ack, overrun_clear, ref_clock_alt, start} = 5'h10;
        {len, base, first_data_pin} = 20'h00001;
        shift_timer_compare = 16'h003F;
        mismatches = 0;
        total_checks = 0;
        seed = $urandom(32'hE9B5);
        @(negedge sys_clk);
        do_reset;
        check(256'({dma_req, status, line_count, store_count}), 256'(0));
        ref_shape(3, 2);
        // Edge pins first, then random pin positions
        for (int j = 0; j < 4; j++) begin
            first_data_pin = 4'(j == 0 ? 0 : (j == 1 ? 8 : $urandom_range(8)));
            // Pin select crosses two pixel flops; let it settle before the line
            repeat (8) @(negedge sys_clk);
            run_line(32);
            wait_store(16'(j + 1));
            check(first_holding_buffer, exp_block(base, 0));
            ack;
        end
        // Two stores in one line with no read between them
        run_line(64);
        wait_store(16'h0006);
        check(first_holding_buffer, exp_block(base, 32));
        check(256'(status.overrun), 256'(1));
        overrun_clear = 1'b1;
        ack;
        overrun_clear = 1'b0;
        @(negedge sys_clk);
        check(256'(status.overrun), 256'(0));
        // Partial group left over is pushed out by the next line
        run_line(40);
        wait_store(16'h0007);
        ack;
        run_line(32);
        wait_store(16'h0008);
        check(first_holding_buffer, exp_block(base, 0));
        ack;
        check(256'(line_count), 256'(7));
        ref_clock_alt = 1'b1;
        first_data_pin = 4'h1;
        do_reset;
        ref_shape(3, 3);
        run_line(32);
        wait_store(16'h0001);
        check(first_holding_buffer, exp_block(base, 0));
        test_done;
    end
endmodule : testbench
